// file: logic/baud_sel_pkg.sv
/*
 * Constants and types for the serial-port baud-rate selection block.
 * Assumes an 8-bit special-register bus with single-cycle write and read strobes.
 */
`default_nettype none

package baud_sel_pkg;

    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] OSC_TRIM_HIGH_ADDR  = 8'h84;
    localparam logic [7:0] OSC_TRIM_LOW_ADDR   = 8'h85;
    localparam logic [7:0] TIMER3_CONTROL_ADDR = 8'hc4;
    localparam logic [7:0] TIMED_ACCESS_ADDR   = 8'hc7;

    // ---------------------------------------------------------------
    // Fields and reset values
    // ---------------------------------------------------------------
    localparam int          T3C_PORT1_DOUBLE_BIT = 7;
    localparam int          T3C_SOURCE_SEL_BIT   = 5;
    localparam logic [7:0]  TIMER3_CONTROL_RESET = 8'h00;
    localparam logic [8:0]  OSC_TRIM_RESET       = 9'h100;
    localparam logic [7:0]  TA_KEY_FIRST         = 8'haa;
    localparam logic [7:0]  TA_KEY_SECOND        = 8'h55;

    // ---------------------------------------------------------------
    // Divide ratios (system clock cycles per baud tick; TIMER_DIV_16 counts timer overflows)
    // ---------------------------------------------------------------
    localparam logic [6:0]  MODE0_DIV_SLOW  = 7'd12;
    localparam logic [6:0]  MODE0_DIV_FAST  = 7'd2;
    localparam logic [6:0]  MODE2_DIV_SLOW  = 7'd64;
    localparam logic [6:0]  MODE2_DIV_FAST  = 7'd32;
    localparam logic [4:0]  TIMER_DIV_16    = 5'd16;

    typedef enum logic [1:0] {
        MODE_SHIFT,
        MODE_ASYNC_TIMER8,
        MODE_ASYNC_FIXED,
        MODE_ASYNC_TIMER9
    } uart_mode_type;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_FIRST_SEEN,
        KEY_OPEN
    } key_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;

    typedef struct packed {
        uart_mode_type mode;
        logic          baud_double;
        logic          multiproc_enable;
    } port_cfg_type;

endpackage

`default_nettype wire

// file: logic/uart_baud_rate_select.sv
/*
 * Baud-rate clock selection for two serial ports, plus the timed-access
 * protected trim of the internal fast oscillator.
 * Assumes Timer 1 and Timer 3 are built elsewhere and each hand over a
 * one-cycle overflow pulse; the Timer 3 pulse already includes its prescale.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Port 0 in mode 1 or 3 counts Timer 1 overflows when the source select is 0, Timer 3 when 1.
// - Port 1 in mode 1 or 3 always counts Timer 3 overflows.
// - Mode 0 ticks at clock/12, or clock/2 when the port's multiprocessor enable is set.
// - Mode 2 ticks at clock/64, or clock/32 when that port's doubling bit is set.
// - On Timer 1 the port-0 rate is overflows divided by 16, or by 32 without doubling.
// - On Timer 3 the port-0 rate is Timer 3 overflows divided by 16 or 32 by doubling.
// - Port 1 rate is Timer 3 overflows divided by 16.
// - The trim is nine bits: bits 8..1 in the high register, bit 0 in the low register.
// - Each trim step moves the oscillator by about a quarter percent, about 40 kHz.
// - Trim resets to the nominal 16 MHz value and any accepted write retunes the oscillator.
module uart_baud_rate_select
    import baud_sel_pkg::*;
#(
    parameter logic [8:0] TRIM_FACTORY = OSC_TRIM_RESET
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire sfr_req_type  sfr_req,
    input  wire port_cfg_type port0_cfg,
    input  wire port_cfg_type port1_cfg,
    input  wire logic         timer1_clock_div_sel,
    input  wire logic         timer1_overflow,
    input  wire logic         timer3_overflow,
    output var  logic [7:0]   sfr_rdata,
    output var  logic         port0_baud_tick,
    output var  logic         port1_baud_tick,
    output var  logic [8:0]   osc_trim_value
);

    // ---------------------------------------------------------------
    // Timed-access key
    // ---------------------------------------------------------------
    key_state_type key_q;
    logic          ta_wr;
    logic          trim_wr_ok;

    assign ta_wr      = sfr_req.wr && sfr_req.addr == TIMED_ACCESS_ADDR;
    assign trim_wr_ok = key_q == KEY_OPEN;

    // Window stays open for exactly the next bus write, whatever its target
    key_state_type key_d;

    always_comb begin
        key_d = key_q;
        if (sfr_req.wr) begin
            unique case (key_q)
                KEY_IDLE: begin
                    key_d = (ta_wr && sfr_req.wdata == TA_KEY_FIRST)
                            ? KEY_FIRST_SEEN : KEY_IDLE;
                end
                KEY_FIRST_SEEN: begin
                    key_d = (ta_wr && sfr_req.wdata == TA_KEY_SECOND)
                            ? KEY_OPEN : KEY_IDLE;
                end
                KEY_OPEN: begin
                    key_d = KEY_IDLE;
                end
                default: begin
                    key_d = KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key_q <= KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] timer3_control_q;
    logic [8:0] trim_q;
    logic       trim_loaded_q;
    logic       port0_baud_source_sel;
    logic       port1_baud_double;

    assign port0_baud_source_sel = timer3_control_q[T3C_SOURCE_SEL_BIT];
    assign port1_baud_double     = timer3_control_q[T3C_PORT1_DOUBLE_BIT];

    logic [7:0] timer3_control_d;

    always_comb begin
        timer3_control_d = timer3_control_q;
        if (sfr_req.wr && sfr_req.addr == TIMER3_CONTROL_ADDR) begin
            timer3_control_d = sfr_req.wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer3_control_q <= TIMER3_CONTROL_RESET;
        end else begin
            timer3_control_q <= timer3_control_d;
        end
    end

    // Factory value is a parameter, so it is caught just after reset release
    logic [8:0] trim_d;

    always_comb begin
        trim_d = trim_q;
        if (!trim_loaded_q) begin
            trim_d = TRIM_FACTORY;
        end else if (sfr_req.wr && trim_wr_ok) begin
            if (sfr_req.addr == OSC_TRIM_HIGH_ADDR) begin
                trim_d[8:1] = sfr_req.wdata;
            end else if (sfr_req.addr == OSC_TRIM_LOW_ADDR) begin
                trim_d[0] = sfr_req.wdata[0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trim_q        <= OSC_TRIM_RESET;
            trim_loaded_q <= 1'b0;
        end else begin
            trim_q        <= trim_d;
            trim_loaded_q <= 1'b1;
        end
    end

    // Oscillator control word; each code step is one quarter-percent step
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_trim_value <= OSC_TRIM_RESET;
        end else begin
            osc_trim_value <= trim_q;
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    // Held between reads so a slow bus master may pick it up late
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = sfr_rdata;
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                OSC_TRIM_HIGH_ADDR:  rdata_d = trim_q[8:1];
                OSC_TRIM_LOW_ADDR:   rdata_d = {7'h00, trim_q[0]};
                TIMER3_CONTROL_ADDR: rdata_d = timer3_control_q;
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Fixed-rate prescaler, shared by mode 0 and mode 2
    // ---------------------------------------------------------------
    // One free-running counter per port; the ratio is picked from mode and bits
    function automatic logic [6:0] fixed_div(input port_cfg_type c);
        logic [6:0] d;
        d = MODE2_DIV_SLOW;
        if (c.mode == MODE_SHIFT) begin
            d = c.multiproc_enable ? MODE0_DIV_FAST : MODE0_DIV_SLOW;
        end else begin
            d = c.baud_double ? MODE2_DIV_FAST : MODE2_DIV_SLOW;
        end
        return d;
    endfunction

    logic [6:0] fix0_q;
    logic [6:0] fix1_q;
    logic       fix0_hit;
    logic       fix1_hit;
    logic [6:0] div0;
    logic [6:0] div1;
    port_cfg_type cfg1_eff;

    // Port 1's doubling bit lives in the Timer 3 control register
    always_comb begin
        cfg1_eff             = port1_cfg;
        cfg1_eff.baud_double = port1_baud_double;
    end

    assign div0     = fixed_div(port0_cfg);
    assign div1     = fixed_div(cfg1_eff);
    assign fix0_hit = fix0_q >= div0 - 7'd1;
    assign fix1_hit = fix1_q >= div1 - 7'd1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fix0_q <= 7'd0;
        end else begin
            fix0_q <= fix0_hit ? 7'd0 : fix0_q + 7'd1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fix1_q <= 7'd0;
        end else begin
            fix1_q <= fix1_hit ? 7'd0 : fix1_q + 7'd1;
        end
    end

    // ---------------------------------------------------------------
    // Timer-driven divide: port 0 16 with doubling, 32 without; port 1 always 16
    // ---------------------------------------------------------------
    // The Timer 1 overflow period already holds the 12 or 1 clock factor,
    // so the clock-divide select only matters to the timer itself.
    logic       t0_src_pulse;
    logic [4:0] tdiv0_q;
    logic [3:0] tdiv1_q;
    logic       tdiv0_hit;
    logic       tdiv1_hit;
    logic       unused_t1m;

    assign unused_t1m   = timer1_clock_div_sel;
    assign t0_src_pulse = port0_baud_source_sel ? timer3_overflow
                                                : timer1_overflow;
    assign tdiv0_hit    = t0_src_pulse &&
                          (port0_cfg.baud_double ? tdiv0_q[3:0] == 4'hf
                                                 : tdiv0_q == 5'h1f);
    assign tdiv1_hit    = timer3_overflow && tdiv1_q == 4'hf;

    logic [4:0] tdiv0_d;
    logic [3:0] tdiv1_d;

    // Counters move only on a source pulse, so a quiet timer freezes the phase
    always_comb begin
        tdiv0_d = tdiv0_q;
        tdiv1_d = tdiv1_q;
        if (t0_src_pulse) begin
            tdiv0_d = tdiv0_hit ? 5'd0 : tdiv0_q + 5'd1;
        end
        if (timer3_overflow) begin
            tdiv1_d = tdiv1_q + 4'd1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdiv0_q <= 5'd0;
        end else begin
            tdiv0_q <= tdiv0_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdiv1_q <= 4'd0;
        end else begin
            tdiv1_q <= tdiv1_d;
        end
    end

    // ---------------------------------------------------------------
    // Tick outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port0_baud_tick <= 1'b0;
        end else begin
            unique case (port0_cfg.mode)
                MODE_SHIFT, MODE_ASYNC_FIXED: port0_baud_tick <= fix0_hit;
                default:                      port0_baud_tick <= tdiv0_hit;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port1_baud_tick <= 1'b0;
        end else begin
            unique case (port1_cfg.mode)
                MODE_SHIFT, MODE_ASYNC_FIXED: port1_baud_tick <= fix1_hit;
                default:                      port1_baud_tick <= tdiv1_hit;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: sim/uart_baud_rate_select_properties.sv
/* Concurrent checks on the baud-rate select block.
   Assumes one clk domain and the block's own register bus. */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_rate_select_properties
    import baud_sel_pkg::*;
(
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire sfr_req_type  sfr_req,
    input wire port_cfg_type port0_cfg,
    input wire port_cfg_type port1_cfg,
    input wire logic         timer1_overflow,
    input wire logic         timer3_overflow,
    input wire logic [7:0]   sfr_rdata,
    input wire logic         port0_baud_tick,
    input wire logic         port1_baud_tick,
    input wire logic [8:0]   osc_trim_value
);
    logic       first_q;
    logic       open_q;
    logic [7:0] ctl_q;
    wire        key_hit = sfr_req.addr == TIMED_ACCESS_ADDR;
    wire        trim_wr = sfr_req.wr && sfr_req.addr[7:1] == OSC_TRIM_HIGH_ADDR[7:1];
    wire        timed0 = port0_cfg.mode inside {MODE_ASYNC_TIMER8, MODE_ASYNC_TIMER9};
    wire        timed1 = port1_cfg.mode inside {MODE_ASYNC_TIMER8, MODE_ASYNC_TIMER9};
    wire        slow0 = port0_cfg.mode == MODE_SHIFT && !port0_cfg.multiproc_enable;
    wire        fast1 = port1_cfg.mode == MODE_ASYNC_FIXED && ctl_q[7];

    // ---------------------------------------------------------------
    // Mirrors of the key and the control register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_q <= 1'b0;
            open_q  <= 1'b0;
        end else if (sfr_req.wr) begin
            first_q <= key_hit && sfr_req.wdata == TA_KEY_FIRST;
            open_q  <= first_q && key_hit && sfr_req.wdata == TA_KEY_SECOND;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q <= TIMER3_CONTROL_RESET;
        end else if (sfr_req.wr && sfr_req.addr == TIMER3_CONTROL_ADDR) begin
            ctl_q <= sfr_req.wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_trim_accept: assert property (trim_wr && !sfr_req.addr[0] && open_q
        |-> ##2 osc_trim_value[8:1] == $past(sfr_req.wdata, 2)) else $error("trim write lost");
    a_trim_refuse: assert property (trim_wr && !open_q |-> ##2 $stable(osc_trim_value))
        else $error("trim changed without key");
    a_trim_readback: assert property (sfr_req.rd && sfr_req.addr == OSC_TRIM_HIGH_ADDR
        && !$past(sfr_req.wr) |=> sfr_rdata == $past(osc_trim_value[8:1])) else $error("trim read");
    a_ctl_readback: assert property (sfr_req.rd && sfr_req.addr == TIMER3_CONTROL_ADDR
        |=> sfr_rdata == $past(ctl_q)) else $error("control read");
    a_src_select: assert property (port0_baud_tick && timed0 |-> (ctl_q[5]
        ? $past(timer3_overflow) || $past(timer3_overflow, 2)
        : $past(timer1_overflow) || $past(timer1_overflow, 2))) else $error("port0 source");
    a_port1_timer3: assert property (port1_baud_tick && timed1
        |-> $past(timer3_overflow) || $past(timer3_overflow, 2)) else $error("port1 source");
    a_mode0_slow: assert property (port0_baud_tick && slow0 ##12 slow0 |-> port0_baud_tick)
        else $error("mode 0 period");
    a_mode2_fast: assert property (port1_baud_tick && fast1 ##32 fast1 |-> port1_baud_tick)
        else $error("mode 2 period");
endmodule

bind uart_baud_rate_select uart_baud_rate_select_properties chk (.clk, .sys_rst, .sfr_req,
    .port0_cfg, .port1_cfg, .timer1_overflow, .timer3_overflow, .sfr_rdata, .port0_baud_tick,
    .port1_baud_tick, .osc_trim_value);
`default_nettype wire

// file: sim/uart_baud_rate_select_tb.sv
/* Self-checking bench for the baud-rate select block.
   Assumes the block is the only thing on its register bus. */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_rate_select_tb
    import baud_sel_pkg::*;
;
    localparam logic [8:0] TRIM_NEW = OSC_TRIM_RESET - 9'h00f;
    logic         clk;
    logic         sys_rst;
    sfr_req_type  sfr_req;
    port_cfg_type port0_cfg;
    port_cfg_type port1_cfg;
    logic         timer1_clock_div_sel;
    logic         timer1_overflow;
    logic         timer3_overflow;
    logic [7:0]   sfr_rdata;
    logic         port0_baud_tick;
    logic         port1_baud_tick;
    logic [8:0]   osc_trim_value;
    int           n_errors = 0;
    int           checked = 0;
    int           p;

    uart_baud_rate_select DUT (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .port0_cfg(port0_cfg), .port1_cfg(port1_cfg),
        .timer1_clock_div_sel(timer1_clock_div_sel), .timer1_overflow(timer1_overflow),
        .timer3_overflow(timer3_overflow), .sfr_rdata(sfr_rdata),
        .port0_baud_tick(port0_baud_tick), .port1_baud_tick(port1_baud_tick),
        .osc_trim_value(osc_trim_value));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Bus and measurement tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        #1 chk({1'b0, sfr_rdata}, {1'b0, exp});
    endtask
    task automatic key;
        wr(TIMED_ACCESS_ADDR, TA_KEY_FIRST);
        wr(TIMED_ACCESS_ADDR, TA_KEY_SECOND);
    endtask
    // Pulses go on even cycles; the last six cycles let trailing ticks land
    task automatic run(input int n, input logic t1, input logic t3, input int e0, input int e1);
        int c0;
        int c1;
        c0 = 0;
        c1 = 0;
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            c0 += port0_baud_tick;
            c1 += port1_baud_tick;
            timer1_overflow <= t1 && k < n - 6 && !k[0];
            timer3_overflow <= t3 && k < n - 6 && !k[0];
        end
        chk(c0[8:0], e0[8:0]);
        chk(c1[8:0], e1[8:0]);
    endtask
    task automatic report_and_stop;
        $display("checked %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_errors++;
        report_and_stop;
    end

    initial begin
        sys_rst = 1'b1;
        sfr_req = '0;
        port0_cfg = '0;
        port1_cfg = '0;
        timer1_clock_div_sel = 1'b0;
        timer1_overflow = 1'b0;
        timer3_overflow = 1'b0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(osc_trim_value, OSC_TRIM_RESET);
        rd(TIMER3_CONTROL_ADDR, TIMER3_CONTROL_RESET);
        rd(OSC_TRIM_HIGH_ADDR, OSC_TRIM_RESET[8:1]);
        rd(OSC_TRIM_LOW_ADDR, {7'h00, OSC_TRIM_RESET[0]});
        rd(8'h10, 8'h00);
        wr(TIMER3_CONTROL_ADDR, 8'ha5);
        rd(TIMER3_CONTROL_ADDR, 8'ha5);
        $display("test registers done");
        // Bare write, then a full key whose window is used up by another write
        wr(OSC_TRIM_HIGH_ADDR, 8'h00);
        key;
        wr(TIMER3_CONTROL_ADDR, 8'h00);
        wr(OSC_TRIM_HIGH_ADDR, 8'h00);
        repeat (3) @(posedge clk);
        chk(osc_trim_value, OSC_TRIM_RESET);
        key;
        wr(OSC_TRIM_HIGH_ADDR, TRIM_NEW[8:1]);
        key;
        wr(OSC_TRIM_LOW_ADDR, {7'h00, TRIM_NEW[0]});
        repeat (3) @(posedge clk);
        chk(osc_trim_value, TRIM_NEW);
        rd(OSC_TRIM_HIGH_ADDR, TRIM_NEW[8:1]);
        rd(OSC_TRIM_LOW_ADDR, {7'h00, TRIM_NEW[0]});
        $display("test trim done");
        // Timer-driven modes, pulse counts kept whole periods
        port0_cfg <= '{MODE_ASYNC_TIMER8, 1'b0, 1'b0};
        port1_cfg <= '{MODE_ASYNC_TIMER9, 1'b0, 1'b0};
        run(646, 1'b1, 1'b0, 320 / (2 * TIMER_DIV_16), 0);
        run(646, 1'b0, 1'b1, 0, 320 / TIMER_DIV_16);
        wr(TIMER3_CONTROL_ADDR, 8'h20);
        port0_cfg.baud_double <= 1'b1;
        run(326, 1'b0, 1'b1, 160 / TIMER_DIV_16, 160 / TIMER_DIV_16);
        run(326, 1'b1, 1'b0, 0, 0);
        $display("test timer sources done");
        // Clock-driven modes: i[1] picks mode 2, i[0] the faster rate
        for (int i = 0; i < 4; i++) begin
            wr(TIMER3_CONTROL_ADDR, {i[0], 7'h00});
            port0_cfg <= '{i[1] ? MODE_ASYNC_FIXED : MODE_SHIFT, i[0], i[0]};
            port1_cfg <= '{i[1] ? MODE_ASYNC_FIXED : MODE_SHIFT, i[0], i[0]};
            p = i[1] ? (i[0] ? MODE2_DIV_FAST : MODE2_DIV_SLOW)
                     : (i[0] ? MODE0_DIV_FAST : MODE0_DIV_SLOW);
            repeat (70) @(posedge clk);
            run(384, 1'b0, 1'b0, 384 / p, 384 / p);
        end
        $display("test clock rates done");
        report_and_stop;
    end
endmodule
`default_nettype wire
